// *** design/rotate_right_no_carry_exec.sv ***
// Rotate-right-without-carry execution slice with APB register access
//
// Operation
// - The result is the source byte rotated right by one with bit 0 wrapping to bit 7, and only N and Z follow it.
// - With the destination bit clear the result goes to the working register and memory is not written.
// - With the destination bit set the result goes back to the byte it was read from and W is untouched.
// - With the access bit clear the operand is resolved in the fixed access window, ignoring the bank register.
// - With the access bit set the address is the bank register joined to the 8-bit operand.
// - The instruction is recognised by upper opcode bits 010000, followed by d, a and an 8-bit file address.
`timescale 1ns/100ps
module rotate_right_no_carry_exec
    import rotate_wrap_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [11:0] mem_addr,
    output logic mem_re,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);
    phase_e phase_reg;
    logic [15:0] instr_reg;
    logic [7:0] work_reg;
    logic [3:0] bank_select_register;
    logic [4:0] status_reg;
    logic illegal_reg;
    logic done_reg;
    logic dest_reg;
    logic [7:0] operand_reg;
    logic [7:0] result_reg;
    logic res_neg_reg;
    logic res_zero_reg;
    logic [11:0] addr_next;
    logic [7:0] rot_result;
    logic rot_neg;
    logic rot_zero;
    logic busy;
    logic setup;
    logic access_done;
    logic mapped;
    logic [31:0] rdata_next;
    logic write_ok;

    assign busy = (phase_reg != PH_IDLE);
    assign setup = psel && !penable;
    assign access_done = psel && penable && pready;
    assign write_ok = access_done && pwrite && mapped && !pslverr;

    always_comb begin
        mapped = 1'b1;
        rdata_next = 32'h0000_0000;
        case (paddr)
            OFS_INSTR: rdata_next[15:0] = instr_reg;
            OFS_WORK: rdata_next[7:0] = work_reg;
            OFS_BANK: rdata_next[3:0] = bank_select_register;
            OFS_STATUS: rdata_next[4:0] = status_reg;
            OFS_INFO: begin
                rdata_next[INFO_BUSY] = busy;
                rdata_next[INFO_ILLEGAL] = illegal_reg;
                rdata_next[INFO_DONE] = done_reg;
            end
            default: mapped = 1'b0;
        endcase
    end

    // Answer one cycle after setup; writes while busy or to holes are refused
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= !mapped || (pwrite && (busy || paddr == OFS_INFO));
            prdata <= pwrite ? 32'h0000_0000 : rdata_next;
        end else if (access_done) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Fixed access window or banked address
    always_comb begin
        if (instr_reg[ACC_BIT]) begin
            addr_next = {bank_select_register, instr_reg[7:0]};
        end else if (instr_reg[7:0] < ACCESS_SPLIT) begin
            addr_next = {ACCESS_LOW_BANK, instr_reg[7:0]};
        end else begin
            addr_next = {ACCESS_HIGH_BANK, instr_reg[7:0]};
        end
    end

    rotate_wrap_unit u_rot (
        .operand(operand_reg),
        .result(rot_result),
        .negative(rot_neg),
        .zero(rot_zero)
    );

    // Four phases: decode, read, process, write
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= PH_IDLE;
        end else begin
            case (phase_reg)
                PH_IDLE: begin
                    if (write_ok && paddr == OFS_INSTR) begin
                        phase_reg <= PH_Q1;
                    end
                end
                PH_Q1: begin
                    if (instr_reg[OPC_HI:OPC_LO] == OPC_ROTATE_RIGHT_WRAP) begin
                        phase_reg <= PH_Q2;
                    end else begin
                        phase_reg <= PH_IDLE;
                    end
                end
                PH_Q2: phase_reg <= PH_Q3;
                PH_Q3: phase_reg <= PH_Q4;
                PH_Q4: phase_reg <= PH_IDLE;
                default: phase_reg <= PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            instr_reg <= INSTR_RESET;
        end else if (write_ok && paddr == OFS_INSTR) begin
            instr_reg <= pwdata[INSTR_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            illegal_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (write_ok && paddr == OFS_INSTR) begin
            illegal_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (phase_reg == PH_Q1) begin
            illegal_reg <= (instr_reg[OPC_HI:OPC_LO] != OPC_ROTATE_RIGHT_WRAP);
        end else if (phase_reg == PH_Q4) begin
            done_reg <= 1'b1;
        end
    end

    // Memory side: address from decode, read in Q2, write back in Q4
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mem_addr <= 12'h000;
            mem_re <= 1'b0;
            mem_we <= 1'b0;
            mem_wdata <= 8'h00;
            dest_reg <= 1'b0;
        end else begin
            mem_re <= (phase_reg == PH_Q1)
                && (instr_reg[OPC_HI:OPC_LO] == OPC_ROTATE_RIGHT_WRAP);
            mem_we <= (phase_reg == PH_Q3) && dest_reg;
            if (phase_reg == PH_Q1) begin
                mem_addr <= addr_next;
                dest_reg <= instr_reg[DEST_BIT];
            end
            if (phase_reg == PH_Q3) begin
                mem_wdata <= rot_result;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            operand_reg <= 8'h00;
        end else if (phase_reg == PH_Q2) begin
            operand_reg <= mem_rdata;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            result_reg <= 8'h00;
            res_neg_reg <= 1'b0;
            res_zero_reg <= 1'b0;
        end else if (phase_reg == PH_Q3) begin
            result_reg <= rot_result;
            res_neg_reg <= rot_neg;
            res_zero_reg <= rot_zero;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            work_reg <= WORK_RESET;
        end else if (phase_reg == PH_Q4 && !dest_reg) begin
            work_reg <= result_reg;
        end else if (write_ok && paddr == OFS_WORK) begin
            work_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bank_select_register <= BANK_RESET;
        end else if (write_ok && paddr == OFS_BANK) begin
            bank_select_register <= pwdata[3:0];
        end
    end

    // Only N and Z follow the result; carry and the rest are kept
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status_reg <= STATUS_RESET;
        end else if (phase_reg == PH_Q4) begin
            status_reg[ST_NEG] <= res_neg_reg;
            status_reg[ST_ZERO] <= res_zero_reg;
        end else if (write_ok && paddr == OFS_STATUS) begin
            status_reg <= pwdata[ST_W-1:0];
        end
    end
endmodule

// *** design/rotate_wrap_pkg.sv ***
// Constants shared by the rotate-right-wrap execution slice
package rotate_wrap_pkg;
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_WORK = 8'h04;
    localparam logic [7:0] OFS_BANK = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_INFO = 8'h10;

    localparam int INSTR_W = 16;
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 10;
    localparam int DEST_BIT = 9;
    localparam int ACC_BIT = 8;
    localparam logic [5:0] OPC_ROTATE_RIGHT_WRAP = 6'h10;

    localparam int ST_CARRY = 0;
    localparam int ST_ZERO = 2;
    localparam int ST_NEG = 4;
    localparam int ST_W = 5;

    localparam int INFO_BUSY = 0;
    localparam int INFO_ILLEGAL = 1;
    localparam int INFO_DONE = 2;

    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    localparam logic [15:0] INSTR_RESET = 16'h0000;

    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    typedef enum logic [4:0] {
        PH_IDLE = 5'b0_0001,
        PH_Q1 = 5'b0_0010,
        PH_Q2 = 5'b0_0100,
        PH_Q3 = 5'b0_1000,
        PH_Q4 = 5'b1_0000
    } phase_e;
endpackage

// *** design/rotate_wrap_unit.sv ***
// Combinational rotate-right-by-one with wraparound and flag results
`timescale 1ns/100ps
module rotate_wrap_unit
    import rotate_wrap_pkg::*;
(
    input wire logic [7:0] operand,
    output logic [7:0] result,
    output logic negative,
    output logic zero
);
    always_comb begin
        result = {operand[0], operand[7:1]};
        negative = result[7];
        zero = (result == 8'h00);
    end
endmodule

// *** tb/rotate_wrap_props.sv ***
// Port checker for the rotate-right-wrap slice
`timescale 1ns/100ps
module rotate_wrap_props
    import rotate_wrap_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] mem_addr,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata
);
    logic [7:0] rd_reg;
    logic [7:0] file_reg;
    logic dest_reg;
    logic go;
    assign go = psel && penable && pready && pwrite && !pslverr && paddr == OFS_INSTR
        && pwdata[OPC_HI:OPC_LO] == OPC_ROTATE_RIGHT_WRAP;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rd_reg <= 8'h00;
            file_reg <= 8'h00;
            dest_reg <= 1'b0;
        end else begin
            if (mem_re) begin
                rd_reg <= mem_rdata;
            end
            if (go) begin
                file_reg <= pwdata[7:0];
                dest_reg <= pwdata[DEST_BIT];
            end
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_ready_one; psel && !penable |=> pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready late");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_re_pulse; mem_re |=> !mem_re; endproperty
    a_re_pulse: assert property (p_re_pulse) else $error("read held");
    property p_start; go |-> ##2 (mem_re && mem_addr[7:0] == file_reg); endproperty
    a_start: assert property (p_start) else $error("read not started");
    property p_window;
        go && !pwdata[ACC_BIT] |-> ##2
            mem_addr[11:8] == (file_reg[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK);
    endproperty
    a_window: assert property (p_window) else $error("bad access bank");
    property p_dest; mem_re |-> ##2 (mem_we == dest_reg); endproperty
    a_dest: assert property (p_dest) else $error("bad destination");
    property p_rot; mem_we |-> mem_wdata == {rd_reg[0], rd_reg[7:1]}; endproperty
    a_rot: assert property (p_rot) else $error("bad rotate");
    property p_we_cause; mem_we |-> $past(mem_re, 2); endproperty
    a_we_cause: assert property (p_we_cause) else $error("stray write");
    // An accepted instruction word with a foreign opcode must touch no memory
    property p_no_exec;
        psel && penable && pready && pwrite && !pslverr && paddr == OFS_INSTR
            && pwdata[OPC_HI:OPC_LO] != OPC_ROTATE_RIGHT_WRAP
            |=> (!mem_re && !mem_we) [*4];
    endproperty
    a_no_exec: assert property (p_no_exec) else $error("foreign opcode ran");
    c_write: cover property (mem_we);
    c_banked: cover property (go && pwdata[ACC_BIT]);
    c_refused: cover property (pready && pslverr);
endmodule

// *** tb/data_mem_model.sv ***
// Banked data memory partner with combinational read
`timescale 1ns/100ps
module data_mem_model (
    input wire logic clock,
    input wire logic [11:0] mem_addr,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:4095];
    // Unread data line shows the inverse so stale data never passes
    assign mem_rdata = mem_re ? mem[mem_addr] : ~mem[mem_addr];
    always @(posedge clock) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule

// *** tb/tb_top.sv ***
// Top-level bench for the rotate-right-wrap slice
`timescale 1ns/100ps
module tb_top
    import rotate_wrap_pkg::*;
;
    logic clock, rstn, psel, penable, pwrite, pready, pslverr, mem_re, mem_we;
    logic [7:0] paddr, mem_wdata, mem_rdata;
    logic [31:0] pwdata, prdata, q;
    logic [11:0] mem_addr;
    logic e;
    int err_total, tests_run;
    rotate_right_no_carry_exec uut (
        .clock(clock),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .mem_addr(mem_addr),
        .mem_re(mem_re),
        .mem_we(mem_we),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata)
    );
    data_mem_model mem_model (
        .clock(clock),
        .mem_addr(mem_addr),
        .mem_re(mem_re),
        .mem_we(mem_we),
        .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata)
    );
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1) begin
            chk(32'(pready), 32'h0000_0001);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        apb(1'b1, a, d);
        chk(32'(e), 32'(ee));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, OFS_INFO, 32'h0000_0000);
            n++;
        end while (q[INFO_BUSY] !== 1'b0 && n < 10);
        chk(32'(q[INFO_BUSY]), 32'h0000_0000);
    endtask
    task automatic t_to_work();
        mem_model.mem[12'h005] = 8'hD7;
        rd(OFS_WORK, 32'h0000_0000);
        rd(OFS_STATUS, 32'h0000_0000);
        wr(OFS_BANK, 32'h0000_0005, 1'b0);
        wr(OFS_STATUS, 32'h0000_0001, 1'b0);
        wr(OFS_INSTR, 32'h0000_4005, 1'b0);
        wait_idle();
        chk(32'(q[INFO_DONE]), 32'h0000_0001);
        chk(32'(q[INFO_ILLEGAL]), 32'h0000_0000);
        rd(OFS_WORK, 32'h0000_00EB);
        rd(OFS_STATUS, 32'h0000_0011);
        chk(32'(mem_model.mem[12'h005]), 32'h0000_00D7);
    endtask
    task automatic t_to_mem();
        mem_model.mem[12'h3A0] = 8'h01;
        wr(OFS_BANK, 32'h0000_0003, 1'b0);
        wr(OFS_STATUS, 32'h0000_000A, 1'b0);
        wr(OFS_INSTR, 32'h0000_43A0, 1'b0);
        wr(OFS_WORK, 32'h0000_0077, 1'b1);
        wait_idle();
        chk(32'(mem_model.mem[12'h3A0]), 32'h0000_0080);
        rd(OFS_WORK, 32'h0000_00EB);
        rd(OFS_STATUS, 32'h0000_001A);
    endtask
    task automatic t_window();
        mem_model.mem[12'hF90] = 8'h00;
        mem_model.mem[12'h390] = 8'h55;
        wr(OFS_INSTR, 32'h0000_4290, 1'b0);
        wait_idle();
        chk(32'(mem_model.mem[12'hF90]), 32'h0000_0000);
        chk(32'(mem_model.mem[12'h390]), 32'h0000_0055);
        rd(OFS_STATUS, 32'h0000_000E);
        rd(OFS_WORK, 32'h0000_00EB);
    endtask
    task automatic t_illegal();
        wr(OFS_INSTR, 32'h0000_4405, 1'b0);
        wait_idle();
        chk(32'(q[INFO_ILLEGAL]), 32'h0000_0001);
        chk(32'(q[INFO_DONE]), 32'h0000_0000);
        rd(OFS_WORK, 32'h0000_00EB);
        wr(OFS_INFO, 32'h0000_0000, 1'b1);
        rd(8'h20, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        t_to_work();
        t_to_mem();
        t_window();
        t_illegal();
        test_done();
    end
    initial begin
        #50000;
        err_total++;
        test_done();
    end
endmodule
bind rotate_right_no_carry_exec rotate_wrap_props u_props (
    .clock(clock),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .mem_addr(mem_addr),
    .mem_re(mem_re),
    .mem_we(mem_we),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata)
);
